// File: core/ballast_pkg.sv
package ballast_pkg;
  // state codes, one-hot
  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_STARTUP = 5'h02,
    ST_PREHEAT = 5'h04,
    ST_IGNITE  = 5'h08,
    ST_RUN     = 5'h10
  } mode_t;

  // digitised comparator results from the analogue front end
  typedef struct packed {
    logic supplyAboveRising;
    logic supplyUndervoltageFalling;
    logic busAboveOn;
    logic busAboveOff;
    logic shutdownAbove;
    logic shutdownBelow;
    logic overTemp;
  } sense_t;

  typedef struct packed {
    logic preheatDone;
    logic preheatTimerNodeHigh;
    logic csOverPos;
    logic csUnderNeg;
  } timing_t;

  localparam logic [4:0] MODE_RESET = 5'h01;
endpackage

// File: core/ballast_protection_sequencer.sv
`timescale 1ns/100ps
module ballast_protection_sequencer
  import ballast_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rstn,
  // comparator results
  input  wire sense_t  sense,
  input  wire timing_t timing,
  // oscillator phase from the analogue oscillator
  input  wire logic    oscHigh,
  input  wire logic    oscLow,
  // gate drive and status
  output logic         high_gate_output,
  output logic         low_gate_output,
  output logic         oscEnable,
  output logic         micropower,
  output logic         faultLatched,
  output mode_t        mode
);

  // mode register and its next value
  mode_t mode_q;
  mode_t mode_d;

  // bus run permission
  logic  busOk_q;
  logic  busOk_d;

  // shutdown edge tracking
  logic  sdPrev_q;
  logic  sdFall;

  // latches
  logic  fault_q;
  logic  fault_d;
  logic  hot_q;
  logic  hot_d;

  // gate registers
  logic  lowGate_q;
  logic  lowGate_d;
  logic  highGate_q;
  logic  highGate_d;

  // decoded conditions
  logic  startReady;
  logic  lowFall;
  logic  overTrip;
  logic  underTrip;
  logic  csFault;
  logic  offCond;
  logic  gateHold;

  // positive check armed once preheat has ended
  function automatic logic overArmed(input mode_t m);
    return (m == ST_IGNITE) || (m == ST_RUN);
  endfunction

  // negative check armed only in run mode
  function automatic logic underArmed(input mode_t m);
    return (m == ST_RUN);
  endfunction

  // off when parked in the idle mode
  function automatic logic isIdle(input mode_t m);
    return (m == ST_OFF);
  endfunction

  // hysteresis: on at the upper threshold, off only below the lower one;
  // the next value is used at once so a low bus stops within one edge
  always_comb begin
    busOk_d = busOk_q;
    if (sense.busAboveOn) begin
      busOk_d = 1'b1;
    end else if (!sense.busAboveOff) begin
      busOk_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busOk_q <= 1'b0;
    end else begin
      busOk_q <= busOk_d;
    end
  end

  // reset value matches the idle level of the flag, so no false edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdPrev_q <= 1'b0;
    end else begin
      sdPrev_q <= sense.shutdownAbove;
    end
  end

  assign sdFall = sdPrev_q && !sense.shutdownAbove;

  // all three start conditions must hold in the same cycle
  assign startReady = sense.supplyAboveRising && sense.busAboveOn && sense.shutdownBelow;

  // falling edge of the low gate as driven from the oscillator
  assign lowFall = lowGate_q && !oscLow;

  // positive check on every cycle, negative check only in the cycle the low gate falls; never averaged
  assign overTrip  = timing.csOverPos && overArmed(mode_q);
  assign underTrip = timing.csUnderNeg && underArmed(mode_q) && lowFall;
  assign csFault   = overTrip || underTrip;

  // set wins over clear
  always_comb begin
    fault_d = fault_q;
    if (csFault) begin
      fault_d = 1'b1;
    end else if (sense.shutdownAbove || sense.supplyUndervoltageFalling) begin
      fault_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  // overtemperature needs a full shutdown cycle or undervoltage to clear
  always_comb begin
    hot_d = hot_q;
    if (sense.overTemp) begin
      hot_d = 1'b1;
    end else if (sdFall || sense.supplyUndervoltageFalling) begin
      hot_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hot_q <= 1'b0;
    end else begin
      hot_q <= hot_d;
    end
  end

  // any off condition forces the idle mode; restart always from the top
  assign offCond = sense.shutdownAbove
                   || !busOk_d
                   || fault_q
                   || hot_q
                   || sense.overTemp
                   || csFault
                   || !sense.supplyAboveRising;

  always_comb begin
    mode_d = mode_q;
    if (offCond) begin
      mode_d = ST_OFF;
    end else begin
      unique case (mode_q)
        ST_OFF: begin
          if (startReady) mode_d = ST_STARTUP;
        end
        ST_STARTUP: begin
          mode_d = ST_PREHEAT;
        end
        ST_PREHEAT: begin
          if (timing.preheatDone) mode_d = ST_IGNITE;
        end
        ST_IGNITE: begin
          if (timing.preheatTimerNodeHigh) mode_d = ST_RUN;
        end
        ST_RUN: begin
          mode_d = ST_RUN;
        end
        default: begin
          mode_d = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= mode_t'(MODE_RESET);
    end else begin
      mode_q <= mode_d;
    end
  end

  // gates follow the oscillator one cycle late; forced low when stopping
  assign gateHold = offCond || isIdle(mode_q);

  always_comb begin
    lowGate_d  = oscLow;
    highGate_d = oscHigh;
    if (gateHold) begin
      lowGate_d  = 1'b0;
      highGate_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lowGate_q <= 1'b0;
    end else begin
      lowGate_q <= lowGate_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highGate_q <= 1'b0;
    end else begin
      highGate_q <= highGate_d;
    end
  end

  // status decoded straight from registers
  assign low_gate_output  = lowGate_q;
  assign high_gate_output = highGate_q;
  assign oscEnable        = !isIdle(mode_q);
  assign micropower       = isIdle(mode_q);
  assign faultLatched     = fault_q | hot_q;
  assign mode             = mode_q;

endmodule

// File: tb/ballast_osc_model.sv
`timescale 1ns/100ps
module ballast_osc_model (
  input  wire logic clk,
  input  wire logic en,
  output logic      oscHigh,
  output logic      oscLow
);
  logic [1:0] ph;
  // phase parks while stopped so no stray edge reaches the gates
  always_ff @(posedge clk) ph <= en ? ph + 2'h1 : 2'h0;
  assign oscHigh = en & (ph == 2'h1);
  assign oscLow  = en & (ph == 2'h3);
endmodule

// File: tb/ballast_monitor.sv
`timescale 1ns/100ps
module ballast_monitor import ballast_pkg::*; (
  // clock and reset
  input wire logic    clk,
  input wire logic    rstn,
  // inputs of the sequencer
  input wire logic    oscHigh,
  input wire logic    oscLow,
  input wire sense_t  sense,
  input wire timing_t timing,
  // outputs of the sequencer
  input wire logic    high_gate_output,
  input wire logic    low_gate_output,
  input wire logic    oscEnable,
  input wire logic    micropower,
  input wire logic    faultLatched,
  input wire mode_t   mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire off = sense.shutdownAbove | !sense.busAboveOff | sense.overTemp | timing.csOverPos | faultLatched
             | !sense.supplyAboveRising;
  shut_off_a: assert property (sense.shutdownAbove |=> mode == ST_OFF && !high_gate_output && !low_gate_output) else $error("shutdown");
  bus_low_a: assert property (!sense.busAboveOff |=> mode == ST_OFF) else $error("low bus");
  start_gate_a: assert property (mode == ST_OFF && !(sense.supplyAboveRising && sense.busAboveOn && sense.shutdownBelow) |=> mode == ST_OFF) else $error("start");
  preheat_cs_a: assert property (mode == ST_PREHEAT && !sense.overTemp |=> !faultLatched) else $error("preheat trip");
  over_trip_a: assert property ((mode == ST_IGNITE || mode == ST_RUN) && timing.csOverPos |=> faultLatched && mode == ST_OFF) else $error("overcurrent");
  under_trip_a: assert property (mode == ST_RUN && low_gate_output && !oscLow && timing.csUnderNeg |=> faultLatched) else $error("undercurrent");
  run_entry_a: assert property (mode == ST_IGNITE && timing.preheatTimerNodeHigh && !off && !sense.supplyUndervoltageFalling |=> mode == ST_RUN) else $error("run");
  uv_clear_a: assert property (mode == ST_OFF && sense.supplyUndervoltageFalling && !sense.overTemp |=> !faultLatched) else $error("uv clear");
  micro_off_a: assert property (mode == ST_OFF |-> micropower && !oscEnable) else $error("micropower");
endmodule
bind ballast_protection_sequencer ballast_monitor i_mon(.*);

// File: tb/ballast_protection_sequencer_tb.sv
`timescale 1ns/100ps
module ballast_protection_sequencer_tb import ballast_pkg::*;;
  logic    clk = 1'b0, rstn = 1'b0, oscHigh, oscLow, hg, lg, oe, mp, fl;
  sense_t  s = 7'h5a;
  timing_t t = 4'h0;
  mode_t   mode;
  int      miscompares = 0, tests_run = 0;
  initial forever #50 clk = ~clk;
  ballast_protection_sequencer i_dut(.clk(clk), .rstn(rstn), .sense(s), .timing(t), .oscHigh(oscHigh), .oscLow(oscLow),
    .high_gate_output(hg), .low_gate_output(lg), .oscEnable(oe), .micropower(mp), .faultLatched(fl), .mode(mode));
  ballast_osc_model i_osc(.clk(clk), .en(oe), .oscHigh(oscHigh), .oscLow(oscLow));
  task complete_run;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input bit ok);
    tests_run++;
    if (!ok) begin
      miscompares++;
      $display("mismatch at %0t: mode %h fault %b", $time, mode, fl);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait; a miss ends the run
  task reach(input mode_t m);
    for (int i = 0; i < 20 && mode !== m; i++) @(negedge clk);
    chk(mode === m);
    if (mode !== m) complete_run;
  endtask
  initial begin
    cyc(5);
    rstn = 1'b1;
    reach(ST_PREHEAT);
    t = 4'h2;
    cyc(3);
    chk(fl === 1'b0 && mode === ST_PREHEAT);
    t = 4'h8;
    reach(ST_IGNITE);
    t = 4'hd;
    reach(ST_OFF);
    chk(fl === 1'b1 && lg === 1'b0 && hg === 1'b0 && mp === 1'b1);
    t = 4'hc;
    s = 7'h5c;
    cyc(2);
    chk(fl === 1'b0 && mode === ST_OFF);
    s = 7'h5a;
    reach(ST_STARTUP);
    reach(ST_RUN);
    s = 7'h42;
    cyc(2);
    chk(mode === ST_OFF && oe === 1'b0);
    s = 7'h4a;
    cyc(3);
    chk(mode === ST_OFF);
    s = 7'h5a;
    reach(ST_STARTUP);
    reach(ST_RUN);
    s = 7'h4a;
    cyc(3);
    chk(mode === ST_RUN);
    s = 7'h5b;
    cyc(2);
    chk(fl === 1'b1 && mode === ST_OFF);
    s = 7'h5c;
    cyc(2);
    chk(fl === 1'b1);
    s = 7'h5a;
    cyc(2);
    chk(fl === 1'b0);
    s = 7'h5b;
    cyc(2);
    s = 7'h3a;
    cyc(2);
    chk(fl === 1'b0);
    complete_run;
  end
endmodule
